// ### hw/dsg_ctrl.sv
// Purpose: Deep-sleep port clock gating and module soft-reset control
// Assumes: Single clock, synchronous active-low reset, plain register port
// Notes:   Run and sleep gating registers kept locally to select the live gate set
// Operation
// - A set gating bit clocks its port, a clear bit leaves it unclocked and disabled.
// - An access to a port whose clock is off is answered with a bus fault.
// - All deep-sleep gating bits are zero after reset.
// - The register at 0x128 steers port clocks only in deep-sleep.
// - Sleep and deep-sleep gating apply only while auto gating is set, else run gating applies.
// - Bits 7..0 of the deep-sleep gate enable ports H..A.
// - Bits 31:8 of the deep-sleep gate read as zero and ignore writes.
// - Writes to the reset control register touch only bits enabled by the capability mask.
// - Reset control bit 16 resets converter module 0.
// - Reset control bit 6 resets the hibernation module.
// - Reset control bit 3 resets the watchdog unit.
// - The reset control register is zero after reset.
// - Unused reset control bits read as zero.
`include "dsg_defs.svh"

module dsg_ctrl
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire dsg_pkg::dsg_bus_req_s   reg_req,
    output logic [31:0]                  reg_rdata,
    // Power state and capability
    input  wire dsg_pkg::dsg_power_e     power_state,
    input  wire logic [31:0]             capabilities_mask_one,
    // Port accesses from the system bus
    input  wire dsg_pkg::dsg_port_access_s port_access,
    output logic                         bus_fault,
    // Port clock enables and module resets
    output logic [7:0]                   port_clock_en,
    output dsg_pkg::dsg_mod_reset_s      mod_reset,
    // Interrupt
    output logic                         irq
);
    import dsg_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]  deep_sleep_port_clock_gate;
    logic [7:0]  run_port_clock_gate;
    logic [7:0]  sleep_port_clock_gate;
    logic        auto_gating_select;
    logic [31:0] module_soft_reset_ctrl;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [7:0]  next_deep_gate;
    logic [7:0]  next_run_gate;
    logic [7:0]  next_sleep_gate;
    logic        next_auto_gate;
    logic [31:0] next_soft_reset;
    logic [1:0]  next_irq_status;
    logic [1:0]  next_irq_mask;
    logic [31:0] next_rdata;
    logic [7:0]  live_gate;
    logic [7:0]  next_clock_en;
    logic        next_fault;
    logic        unmapped;
    logic [1:0]  irq_events;
    logic [31:0] wmask;

    // ----------------------------------------
    // Live gate selection
    // ----------------------------------------
    always_comb
    begin
        live_gate = run_port_clock_gate;
        if (auto_gating_select)
        begin
            unique case (power_state)
                DSG_RUN:   live_gate = run_port_clock_gate;
                DSG_SLEEP: live_gate = sleep_port_clock_gate;
                DSG_DEEP:  live_gate = deep_sleep_port_clock_gate;
                default:   live_gate = run_port_clock_gate;
            endcase
        end
    end

    // ----------------------------------------
    // Per-port clock enables
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `DSG_PORTS; gi = gi + 1)
        begin : g_port
            assign next_clock_en[gi] = live_gate[gi];
        end
    endgenerate

    // ----------------------------------------
    // Register address decode
    // ----------------------------------------
    logic           wr_deep_gate;
    logic           wr_run_gate;
    logic           wr_sleep_gate;
    logic           wr_run_cfg;
    logic           wr_soft_reset;
    logic           wr_irq_mask;
    logic           wr_irq_status;
    logic           wr_unmapped;
    logic           rd_unmapped;
    dsg_mod_reset_s next_mod_reset;
    logic           next_irq;

    always_comb
    begin
        wr_deep_gate  = 1'h0;
        wr_run_gate   = 1'h0;
        wr_sleep_gate = 1'h0;
        wr_run_cfg    = 1'h0;
        wr_soft_reset = 1'h0;
        wr_irq_mask   = 1'h0;
        wr_irq_status = 1'h0;
        wr_unmapped   = 1'h0;
        if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                `DSG_OFS_DEEP_GATE:  wr_deep_gate  = 1'h1;
                `DSG_OFS_RUN_GATE:   wr_run_gate   = 1'h1;
                `DSG_OFS_SLEEP_GATE: wr_sleep_gate = 1'h1;
                `DSG_OFS_RUN_CFG:    wr_run_cfg    = 1'h1;
                `DSG_OFS_SOFT_RESET: wr_soft_reset = 1'h1;
                `DSG_OFS_IRQ_MASK:   wr_irq_mask   = 1'h1;
                `DSG_OFS_IRQ_STATUS: wr_irq_status = 1'h1;
                default:             wr_unmapped   = 1'h1;
            endcase
        end
    end

    // ----------------------------------------
    // Gating registers
    // ----------------------------------------
    always_comb
    begin
        next_deep_gate  = deep_sleep_port_clock_gate;
        next_run_gate   = run_port_clock_gate;
        next_sleep_gate = sleep_port_clock_gate;
        if (wr_deep_gate)
        begin
            next_deep_gate = reg_req.wdata[7:0];
        end
        if (wr_run_gate)
        begin
            next_run_gate = reg_req.wdata[7:0];
        end
        if (wr_sleep_gate)
        begin
            next_sleep_gate = reg_req.wdata[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            deep_sleep_port_clock_gate <= `DSG_GATE_RESET;
            run_port_clock_gate        <= `DSG_GATE_RESET;
            sleep_port_clock_gate      <= `DSG_GATE_RESET;
        end
        else
        begin
            deep_sleep_port_clock_gate <= next_deep_gate;
            run_port_clock_gate        <= next_run_gate;
            sleep_port_clock_gate      <= next_sleep_gate;
        end
    end

    // ----------------------------------------
    // Run configuration
    // ----------------------------------------
    always_comb
    begin
        next_auto_gate = auto_gating_select;
        if (wr_run_cfg)
        begin
            next_auto_gate = reg_req.wdata[`DSG_AUTO_GATE_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            auto_gating_select <= `DSG_AUTO_GATE_RESET;
        end
        else
        begin
            auto_gating_select <= next_auto_gate;
        end
    end

    // ----------------------------------------
    // Soft reset control
    // ----------------------------------------
    always_comb
    begin
        wmask           = capabilities_mask_one & `DSG_SOFT_RESET_WMASK;
        next_soft_reset = module_soft_reset_ctrl;
        if (wr_soft_reset)
        begin
            next_soft_reset = (module_soft_reset_ctrl & ~wmask) | (reg_req.wdata & wmask);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            module_soft_reset_ctrl <= `DSG_SOFT_RESET_RESET;
        end
        else
        begin
            module_soft_reset_ctrl <= next_soft_reset;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    always_comb
    begin
        unmapped                          = wr_unmapped || rd_unmapped;
        irq_events                        = 2'h0;
        irq_events[`DSG_IRQ_FAULT_BIT]    = next_fault;
        irq_events[`DSG_IRQ_UNMAPPED_BIT] = unmapped;
        next_irq_mask                     = irq_mask;
        next_irq_status                   = irq_status;
        if (wr_irq_mask)
        begin
            next_irq_mask = reg_req.wdata[1:0];
        end
        if (wr_irq_status)
        begin
            next_irq_status = irq_status & ~reg_req.wdata[1:0];
        end
        next_irq_status = next_irq_status | irq_events;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_status <= `DSG_IRQ_RESET;
            irq_mask   <= `DSG_IRQ_RESET;
        end
        else
        begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb
    begin
        next_rdata  = 32'h0000_0000;
        rd_unmapped = 1'h0;
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                `DSG_OFS_DEEP_GATE:   next_rdata = {24'h00_0000, deep_sleep_port_clock_gate};
                `DSG_OFS_RUN_GATE:    next_rdata = {24'h00_0000, run_port_clock_gate};
                `DSG_OFS_SLEEP_GATE:  next_rdata = {24'h00_0000, sleep_port_clock_gate};
                `DSG_OFS_RUN_CFG:     next_rdata = {4'h0, auto_gating_select, 27'h000_0000};
                `DSG_OFS_SOFT_RESET:  next_rdata = module_soft_reset_ctrl;
                `DSG_OFS_CAPS_ONE:    next_rdata = capabilities_mask_one;
                `DSG_OFS_IRQ_STATUS:  next_rdata = {30'h0000_0000, irq_status};
                `DSG_OFS_IRQ_MASK:    next_rdata = {30'h0000_0000, irq_mask};
                `DSG_OFS_POWER_STATE: next_rdata = {29'h0000_0000, power_state};
                default:              rd_unmapped = 1'h1;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb
    begin
        next_fault               = port_access.valid && ((port_access.port_sel & live_gate) == 8'h00);
        next_mod_reset.adc       = next_soft_reset[`DSG_ADC_RST_BIT];
        next_mod_reset.hibernate = next_soft_reset[`DSG_HIBERNATE_RST_BIT];
        next_mod_reset.watchdog  = next_soft_reset[`DSG_WATCHDOG_RST_BIT];
        next_irq                 = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            port_clock_en <= 8'h00;
            bus_fault     <= 1'h0;
            mod_reset     <= '0;
            irq           <= 1'h0;
        end
        else
        begin
            port_clock_en <= next_clock_en;
            bus_fault     <= next_fault;
            mod_reset     <= next_mod_reset;
            irq           <= next_irq;
        end
    end
endmodule

// ### hw/dsg_defs.svh
// Purpose: Offsets, field positions and reset values of the gating and soft-reset block
// Assumes: 32-bit register word, byte addresses
// Notes:   Definitions only
`ifndef DSG_DEFS_SVH
`define DSG_DEFS_SVH

`define DSG_ADDR_W              12
`define DSG_OFS_SOFT_RESET      12'h040
`define DSG_OFS_DEEP_GATE       12'h128
`define DSG_OFS_RUN_GATE        12'h108
`define DSG_OFS_SLEEP_GATE      12'h118
`define DSG_OFS_RUN_CFG         12'h060
`define DSG_OFS_CAPS_ONE        12'h010
`define DSG_OFS_IRQ_STATUS      12'h200
`define DSG_OFS_IRQ_MASK        12'h204
`define DSG_OFS_POWER_STATE     12'h208
`define DSG_AUTO_GATE_BIT       27
`define DSG_ADC_RST_BIT         16
`define DSG_HIBERNATE_RST_BIT   6
`define DSG_WATCHDOG_RST_BIT    3
`define DSG_SOFT_RESET_WMASK    32'h0001_0048
`define DSG_GATE_RESET          8'h00
`define DSG_SOFT_RESET_RESET    32'h0000_0000
`define DSG_RUN_CFG_RESET       32'h0000_0000
`define DSG_AUTO_GATE_RESET     1'h0
`define DSG_IRQ_RESET           2'h0
`define DSG_CAPS_ONE_DEFAULT    32'h0001_0048
`define DSG_PORTS               8
`define DSG_IRQ_FAULT_BIT       0
`define DSG_IRQ_UNMAPPED_BIT    1

`endif

// ### hw/dsg_pkg.sv
// Purpose: Types of the gating and soft-reset block
// Assumes: dsg_defs.svh holds the numbers
// Notes:   Power states one-hot
package dsg_pkg;
    typedef enum logic [2:0]
    {
        DSG_RUN   = 3'h1,
        DSG_SLEEP = 3'h2,
        DSG_DEEP  = 3'h4
    } dsg_power_e;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } dsg_bus_req_s;

    typedef struct packed
    {
        logic [7:0] port_sel;
        logic       valid;
    } dsg_port_access_s;

    typedef struct packed
    {
        logic adc;
        logic hibernate;
        logic watchdog;
    } dsg_mod_reset_s;
endpackage

// ### testbench/dsg_ctrl_props.sv
// Purpose: Port checks of the gating and soft-reset block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every dsg_ctrl
module dsg_ctrl_props
(
    // Inputs
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire dsg_pkg::dsg_bus_req_s     reg_req,
    input wire dsg_pkg::dsg_power_e       power_state,
    input wire logic [31:0]               capabilities_mask_one,
    input wire dsg_pkg::dsg_port_access_s port_access,
    // Outputs
    input wire logic [31:0]               reg_rdata,
    input wire logic                      bus_fault,
    input wire logic [7:0]                port_clock_en,
    input wire dsg_pkg::dsg_mod_reset_s   mod_reset,
    input wire logic                      irq
);
    import dsg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic sw  = reg_req.wr && reg_req.addr == 12'h040;
    wire logic adc = sw && reg_req.wdata[16] && capabilities_mask_one[16];
    wire logic hbn = sw && reg_req.wdata[6] && capabilities_mask_one[6];
    wire logic wdg = sw && reg_req.wdata[3] && capabilities_mask_one[3];
    wire logic adc_clr = sw && !reg_req.wdata[16] && capabilities_mask_one[16];
    sequence off_acc;
        port_access.valid && (port_access.port_sel & port_clock_en) == 8'h00;
    endsequence
    sequence on_acc;
        port_access.valid && (port_access.port_sel & port_clock_en) != 8'h00;
    endsequence
    gate_fault_a: assert property (off_acc ##1 $stable(port_clock_en) |-> bus_fault)
        else $error("gated access without fault");
    gate_pass_a: assert property (on_acc ##1 $stable(port_clock_en) |-> !bus_fault)
        else $error("clocked access faulted");
    fault_cause_a: assert property (bus_fault |-> $past(port_access.valid))
        else $error("fault without access");
    reset_zero_a: assert property ($rose(rst_n) |-> port_clock_en == 8'h00 && mod_reset == 3'h0)
        else $error("outputs not clear after reset");
    adc_set_a: assert property ($rose(mod_reset.adc) |-> $past(adc) || $past(adc, 2))
        else $error("converter reset without write");
    hibernate_set_a: assert property ($rose(mod_reset.hibernate) |-> $past(hbn) || $past(hbn, 2))
        else $error("hibernate reset without write");
    watchdog_set_a: assert property ($rose(mod_reset.watchdog) |-> $past(wdg) || $past(wdg, 2))
        else $error("watchdog reset without write");
    adc_hold_a: assert property ($fell(mod_reset.adc) && $past(rst_n) |-> $past(adc_clr) || $past(adc_clr, 2))
        else $error("converter released without write");
endmodule

bind dsg_ctrl dsg_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .power_state(power_state),
    .capabilities_mask_one(capabilities_mask_one), .port_access(port_access), .reg_rdata(reg_rdata),
    .bus_fault(bus_fault), .port_clock_en(port_clock_en), .mod_reset(mod_reset), .irq(irq));

// ### testbench/tb_top.sv
// Purpose: Self-checking bench of the gating and soft-reset block
// Assumes: Inputs driven by non-blocking assignment at rising edges
// Notes:   Reset-value reads first, then row table, gating, interrupt and reset cases
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dsg_pkg::*;
    logic clk, rst_n, fault, irq;
    logic [31:0] rdata, cap;
    logic [7:0] pce;
    dsg_bus_req_s req;
    dsg_power_e pwr;
    dsg_port_access_s acc;
    dsg_mod_reset_s mres;
    int n_fail, cmp_count;
    // Rows: capability, offset, write data, read back, module resets {converter, hibernate, watchdog}
    logic [31:0] rows [7][5] = '{'{32'hFFFFFFFF, 32'h128, 32'hFFFFFFFF, 32'h000000FF, 32'h0},
        '{32'hFFFFFFFF, 32'h128, 32'h000000A5, 32'h000000A5, 32'h0},
        '{32'hFFFFFFFF, 32'h040, 32'hFFFFFFFF, 32'h00010048, 32'h7},
        '{32'h00000008, 32'h040, 32'h00000000, 32'h00010040, 32'h6},
        '{32'h00010000, 32'h040, 32'h00000000, 32'h00000040, 32'h2},
        '{32'hFFFFFFFF, 32'h040, 32'h00000000, 32'h00000000, 32'h0},
        '{32'h00000000, 32'h040, 32'hFFFFFFFF, 32'h00000000, 32'h0}};
    dsg_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .power_state(pwr),
        .capabilities_mask_one(cap), .port_access(acc), .bus_fault(fault), .port_clock_en(pce),
        .mod_reset(mres), .irq(irq));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req.rd <= 1'h0;
        #1 chk("reg_rdata", exp, rdata);
    endtask
    task automatic hit(input logic [7:0] sel, input logic exp);
        @(posedge clk);
        acc <= '{port_sel: sel, valid: 1'h1};
        @(posedge clk);
        acc.valid <= 1'h0;
        #1 chk("bus_fault", {31'h0, exp}, {31'h0, fault});
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial
    begin
        rst_n = 1'h0;
        req = '0;
        cap = 32'hFFFFFFFF;
        pwr = DSG_RUN;
        acc = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        rd(12'h128, 32'h0);
        rd(12'h040, 32'h0);
        foreach (rows[i])
        begin
            @(posedge clk) cap <= rows[i][0];
            wr(rows[i][1][11:0], rows[i][2]);
            rd(rows[i][1][11:0], rows[i][3]);
            chk("mod_reset", rows[i][4], {29'h0, mres});
        end
        @(posedge clk) pwr <= DSG_DEEP;
        wr(12'h108, 32'h30);
        wr(12'h128, 32'h05);
        chk("port_clock_en", 32'h30, {24'h0, pce});
        wr(12'h060, 32'h08000000);
        chk("port_clock_en", 32'h05, {24'h0, pce});
        hit(8'h02, 1'h1);
        hit(8'h04, 1'h0);
        @(posedge clk) pwr <= DSG_SLEEP;
        wr(12'h118, 32'h0);
        hit(8'h20, 1'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(12'h204, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(12'h200, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        rd(12'h300, 32'h0);
        rd(12'h200, 32'h2);
        @(posedge clk) cap <= 32'hFFFFFFFF;
        wr(12'h040, 32'hFFFFFFFF);
        @(posedge clk) rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk("mod_reset", 32'h0, {29'h0, mres});
        @(posedge clk) rst_n <= 1'h1;
        rd(12'h128, 32'h0);
        summarize();
    end
endmodule
